/* msr_bank.sv */
// Special register bank of the CPU with APB access
`timescale 1ns/1ps
`default_nettype none
`include "msr_cfg.svh"
module msr_bank
    import msr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] flash_status,
    output logic [7:0] flash_command_code,
    output logic flash_cmd_stb,
    output logic [15:0] data_pointer,
    input wire logic oscillator_input_pin_i,
    output logic oscillator_input_pin_o,
    output logic oscillator_input_pin_oe,
    output logic flash_busy
);
    logic wr_stb;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ptrl_ff, ptrh_ff, cdiv_ff, aux_ff, cpa_ff, cpb_ff;
    logic [7:0] brgc_ff, brl_ff, brh_ff, twc_ff, twd_ff, twa_ff;
    logic [7:0] accu_ff, fld_ff, fal_ff, fah_ff, mda_ff;
    logic [7:0] flc_ff;
    logic [7:0] cmd_ff;
    logic cmd_stb_ff;
    logic [7:0] clksel_ff;
    logic [7:0] rd_byte;
    logic [7:0] bop_adr;
    logic [2:0] bop_idx;
    logic bop_wr;
    logic bop_val;
    logic [7:0] bop_mask;
    logic [7:0] port_ctl_ff;
    logic pin_is_port;
    logic port_in;

    msr_apb_if i_msr_apb_if (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pready(pready),
        .wr_stb(wr_stb),
        .rd_stb()
    );

    msr_pin_mux i_msr_pin_mux (
        .pclk(pclk),
        .presetn(presetn),
        .clk_src(clksel_ff[`MSR_CS_SRC_HI:`MSR_CS_SRC_LO]),
        .osc_feeds_timer(clksel_ff[`MSR_CS_TMR]),
        .port_out(port_ctl_ff[`MSR_PC_OUT]),
        .port_oe(port_ctl_ff[`MSR_PC_OE]),
        .oscillator_input_pin_i(oscillator_input_pin_i),
        .oscillator_input_pin_o(oscillator_input_pin_o),
        .oscillator_input_pin_oe(oscillator_input_pin_oe),
        .pin_is_port(pin_is_port),
        .port_in_ff(port_in)
    );

    // Word index of the bus address (paddr[9:2]) selects the register
    assign wa = paddr[`MSR_PA_HI:`MSR_PA_LO];
    assign wd = pwdata[7:0];
    assign pslverr = 1'b0;

    // Single-bit access decoded from a write to the bit access register
    assign bop_adr = pwdata[`MSR_BOP_ADR_HI:`MSR_BOP_ADR_LO];
    assign bop_idx = pwdata[`MSR_BOP_IDX_HI:0];
    assign bop_wr = wr_stb && (wa == `MSR_A_BITOP) && pwdata[`MSR_BOP_WR];
    assign bop_val = pwdata[`MSR_BOP_VAL];
    assign bop_mask = 8'h01 << bop_idx;

    function automatic logic [7:0] bit_upd(input logic [7:0] cur);
        bit_upd = bop_val ? (cur | bop_mask) : (cur & ~bop_mask);
    endfunction : bit_upd

    // Bit-addressable registers: byte write or single-bit write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accu_ff <= `MSR_RST_ZERO;
            mda_ff <= `MSR_RST_ZERO;
            twc_ff <= `MSR_RST_ZERO;
        end else begin
            if (wr_stb && wa == `MSR_A_ACCU) begin
                accu_ff <= wd;
            end else if (bop_wr && bop_adr == `MSR_A_ACCU) begin
                accu_ff <= bit_upd(accu_ff);
            end
            if (wr_stb && wa == `MSR_A_MDA) begin
                mda_ff <= wd;
            end else if (bop_wr && bop_adr == `MSR_A_MDA) begin
                mda_ff <= bit_upd(mda_ff);
            end
            if (wr_stb && wa == `MSR_A_TWC) begin
                twc_ff <= wd & `MSR_TWC_WMASK;
            end else if (bop_wr && bop_adr == `MSR_A_TWC) begin
                twc_ff <= bit_upd(twc_ff) & `MSR_TWC_WMASK;
            end
        end
    end

    // Plain byte registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptrl_ff <= `MSR_RST_ZERO;
            ptrh_ff <= `MSR_RST_ZERO;
            cdiv_ff <= `MSR_RST_ZERO;
            aux_ff <= `MSR_RST_ZERO;
            cpa_ff <= `MSR_RST_ZERO;
            cpb_ff <= `MSR_RST_ZERO;
            brgc_ff <= `MSR_RST_ZERO;
            brl_ff <= `MSR_RST_ZERO;
            brh_ff <= `MSR_RST_ZERO;
            twd_ff <= `MSR_RST_ZERO;
            twa_ff <= `MSR_RST_ZERO;
            fld_ff <= `MSR_RST_ZERO;
            fal_ff <= `MSR_RST_ZERO;
            fah_ff <= `MSR_RST_ZERO;
            clksel_ff <= `MSR_RST_ZERO;
            port_ctl_ff <= `MSR_RST_ZERO;
        end else if (wr_stb) begin
            unique case (wa)
                `MSR_A_PTRL: ptrl_ff <= wd;
                `MSR_A_PTRH: ptrh_ff <= wd;
                `MSR_A_CDIV: cdiv_ff <= wd;
                `MSR_A_AUX: aux_ff <= wd & `MSR_AUX_WMASK;
                `MSR_A_CPA: cpa_ff <= wd & `MSR_CMP_WMASK;
                `MSR_A_CPB: cpb_ff <= wd & `MSR_CMP_WMASK;
                `MSR_A_BRGC: brgc_ff <= wd & `MSR_BRGC_WMASK;
                `MSR_A_BRL: brl_ff <= wd;
                `MSR_A_BRH: brh_ff <= wd;
                `MSR_A_TWD: twd_ff <= wd;
                `MSR_A_TWA: twa_ff <= wd;
                `MSR_A_FLD: fld_ff <= wd;
                `MSR_A_FAL: fal_ff <= wd;
                `MSR_A_FAH: fah_ff <= wd;
                `MSR_A_CLKSEL: clksel_ff <= wd;
                `MSR_A_PORT: port_ctl_ff <= wd;
                // Bit-addressable and flash writes are handled elsewhere; unmapped writes are ignored
                default: ;
            endcase
        end
    end

    // Flash control: writes load a command, status comes from the flash side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= `MSR_RST_ZERO;
            cmd_stb_ff <= 1'b0;
            flc_ff <= `MSR_RST_FLC;
        end else begin
            cmd_stb_ff <= wr_stb && (wa == `MSR_A_FLC);
            if (wr_stb && wa == `MSR_A_FLC) begin
                cmd_ff <= wd;
            end
            // Status byte keeps reserved middle bits as reset left them
            flc_ff <= {flash_busy, flc_ff[`MSR_FLC_RSV_HI:`MSR_FLC_RSV_LO], flash_status};
        end
    end

    // Busy from the command strobe until the flash reports a nonzero status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_busy <= 1'b0;
        end else if (wr_stb && wa == `MSR_A_FLC) begin
            flash_busy <= 1'b1;
        end else if (flash_status != 4'h0) begin
            flash_busy <= 1'b0;
        end
    end

    assign flash_command_code = cmd_ff;
    assign flash_cmd_stb = cmd_stb_ff;
    assign data_pointer = {ptrh_ff, ptrl_ff};

    always_comb begin
        rd_byte = 8'h00;
        unique case (wa)
            `MSR_A_PTRL: rd_byte = ptrl_ff;
            `MSR_A_PTRH: rd_byte = ptrh_ff;
            `MSR_A_CDIV: rd_byte = cdiv_ff;
            `MSR_A_AUX: rd_byte = (aux_ff & ~`MSR_AUX_Z0) | `MSR_AUX_O1;
            `MSR_A_CPA: rd_byte = cpa_ff;
            `MSR_A_CPB: rd_byte = cpb_ff;
            `MSR_A_BRGC: rd_byte = brgc_ff;
            `MSR_A_BRL: rd_byte = brl_ff;
            `MSR_A_BRH: rd_byte = brh_ff;
            `MSR_A_TWC: rd_byte = twc_ff;
            `MSR_A_TWD: rd_byte = twd_ff;
            `MSR_A_TWA: rd_byte = twa_ff;
            `MSR_A_ACCU: rd_byte = accu_ff;
            `MSR_A_FLC: rd_byte = flc_ff;
            `MSR_A_FLD: rd_byte = fld_ff;
            `MSR_A_FAL: rd_byte = fal_ff;
            `MSR_A_FAH: rd_byte = fah_ff;
            `MSR_A_MDA: rd_byte = mda_ff;
            `MSR_A_CLKSEL: begin
                rd_byte = {pin_is_port, port_in, 3'h0, clksel_ff[`MSR_CS_TMR:`MSR_CS_SRC_LO]};
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // Read data captured in a flop in the read setup phase and held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end
endmodule : msr_bank
`default_nettype wire

/* msr_cfg.svh */
// Register map constants for the special register bank
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH

`define MSR_A_PTRL 8'h82
`define MSR_A_PTRH 8'h83
`define MSR_A_CDIV 8'h95
`define MSR_A_AUX 8'hA2
`define MSR_A_CPA 8'hAC
`define MSR_A_CPB 8'hAD
`define MSR_A_BRGC 8'hBD
`define MSR_A_BRL 8'hBE
`define MSR_A_BRH 8'hBF
`define MSR_A_TWC 8'hD8
`define MSR_A_TWD 8'hDA
`define MSR_A_TWA 8'hDB
`define MSR_A_ACCU 8'hE0
`define MSR_A_FLC 8'hE4
`define MSR_A_FLD 8'hE5
`define MSR_A_FAL 8'hE6
`define MSR_A_FAH 8'hE7
`define MSR_A_MDA 8'hF0
// Own registers: bit access port, clock source/pin-use control
`define MSR_A_BITOP 8'hFC
`define MSR_A_CLKSEL 8'hFD
// Port control for the oscillator pin; reads back zero
`define MSR_A_PORT 8'hFE

`define MSR_RST_ZERO 8'h00
`define MSR_RST_FLC 8'h70
// Fixed-zero / writable masks
`define MSR_AUX_WMASK 8'hF9
`define MSR_AUX_Z0 8'h04
// No bit is fixed at one in this map; the read path still ORs it in
`define MSR_AUX_O1 8'h00
`define MSR_BRGC_WMASK 8'h03
`define MSR_CMP_WMASK 8'h3F
`define MSR_TWC_WMASK 8'h7D
// Bit access register: [7] write, [6] value, [2:0] bit index; upper address in [15:8]
`define MSR_BOP_WR 7
`define MSR_BOP_VAL 6
`define MSR_BOP_IDX_HI 2
`define MSR_BOP_ADR_LO 8
`define MSR_BOP_ADR_HI 15
// Clock select bits
`define MSR_CS_SRC_LO 0
`define MSR_CS_SRC_HI 1
`define MSR_CS_TMR 2
// Register address field of the bus address (word index)
`define MSR_PA_LO 2
`define MSR_PA_HI 9
// Reserved status bits of the flash control read value
`define MSR_FLC_RSV_LO 4
`define MSR_FLC_RSV_HI 6
// Port control bits
`define MSR_PC_OUT 0
`define MSR_PC_OE 1

`endif

/* msr_pkg.sv */
// Types shared by the special register bank
package msr_pkg;
    typedef enum logic [1:0] {
        MSR_CLK_EXT = 2'h0,
        MSR_CLK_RC = 2'h1,
        MSR_CLK_WDT = 2'h2,
        MSR_CLK_RSV = 2'h3
    } msr_clksrc_t;

    typedef enum logic [2:0] {
        MSR_IDLE = 3'b001,
        MSR_SETUP = 3'b010,
        MSR_ACCESS = 3'b100
    } msr_apb_st_t;
endpackage : msr_pkg

/* msr_apb_if.sv */
// APB slave front end: tracks phases and issues one write or read strobe
`timescale 1ns/1ps
`default_nettype none
module msr_apb_if
    import msr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    output logic pready,
    output logic wr_stb,
    output logic rd_stb
);
    msr_apb_st_t st_ff;
    msr_apb_st_t nxt_st;

    // Zero wait state slave
    assign pready = 1'b1;
    // State shows SETUP during the access cycle; gating on it keeps a
    // penable lingering for one cycle from issuing a second strobe
    assign wr_stb = psel && penable && pwrite && (st_ff == MSR_SETUP);
    assign rd_stb = psel && penable && !pwrite && (st_ff == MSR_SETUP);

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            MSR_IDLE: if (psel) nxt_st = MSR_SETUP;
            MSR_SETUP: nxt_st = MSR_ACCESS;
            MSR_ACCESS: nxt_st = psel ? MSR_SETUP : MSR_IDLE;
            default: nxt_st = MSR_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= MSR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : msr_apb_if
`default_nettype wire

/* msr_pin_mux.sv */
// Decides whether the oscillator input pin may act as a port bit
`timescale 1ns/1ps
`default_nettype none
module msr_pin_mux
    import msr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] clk_src,
    input wire logic osc_feeds_timer,
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic oscillator_input_pin_i,
    output logic oscillator_input_pin_o,
    output logic oscillator_input_pin_oe,
    output logic pin_is_port,
    output logic port_in_ff
);
    logic use_port;

    // Only internal RC or watchdog clock and no timer use frees the pin
    assign use_port = ((clk_src == MSR_CLK_RC) || (clk_src == MSR_CLK_WDT))
                      && !osc_feeds_timer;
    assign pin_is_port = use_port;
    assign oscillator_input_pin_o = port_out;
    assign oscillator_input_pin_oe = use_port && port_oe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_in_ff <= 1'b0;
        end else begin
            port_in_ff <= use_port ? oscillator_input_pin_i : 1'b0;
        end
    end
endmodule : msr_pin_mux
`default_nettype wire

/* msr_bank_props.sv */
// Port-level checks of the special register bank
`timescale 1ns/1ps
`default_nettype none
module msr_bank_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] flash_status,
    input wire logic [7:0] flash_command_code,
    input wire logic flash_cmd_stb,
    input wire logic [15:0] data_pointer,
    input wire logic flash_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bus_wr;
    logic bus_rd;
    assign bus_wr = psel && penable && pwrite;
    assign bus_rd = psel && penable && !pwrite;
    property p_cmd_load;
        bus_wr && paddr[9:2] == 8'hE4 |=> flash_command_code == $past(pwdata[7:0]);
    endproperty
    a_cmd_load: assert property (p_cmd_load) else $error("command code not loaded");
    property p_cmd_stb;
        bus_wr && paddr[9:2] == 8'hE4 |=> flash_cmd_stb && flash_busy;
    endproperty
    a_cmd_stb: assert property (p_cmd_stb) else $error("command strobe or busy missing");
    property p_stb_cause;
        flash_cmd_stb |-> $past(bus_wr) && $past(paddr[9:2]) == 8'hE4;
    endproperty
    a_stb_cause: assert property (p_stb_cause) else $error("strobe without write");
    property p_busy_clr;
        flash_busy && flash_status != 4'h0 && !bus_wr |-> ##[1:2] !flash_busy;
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
    property p_fc_read;
        bus_rd && paddr[9:2] == 8'hE4 |-> prdata[6:4] == 3'b111 && prdata[31:8] == 24'h00_0000;
    endproperty
    a_fc_read: assert property (p_fc_read) else $error("flash status read wrong");
    property p_aux_zero;
        bus_rd && paddr[9:2] == 8'hA2 |-> !prdata[2];
    endproperty
    a_aux_zero: assert property (p_aux_zero) else $error("fixed zero bit set");
    property p_dp_low;
        bus_wr && paddr[9:2] == 8'h82 |=> data_pointer[7:0] == $past(pwdata[7:0]);
    endproperty
    a_dp_low: assert property (p_dp_low) else $error("pointer low not loaded");
    property p_dp_high;
        bus_wr && paddr[9:2] == 8'h83 |=> data_pointer[15:8] == $past(pwdata[7:0]);
    endproperty
    a_dp_high: assert property (p_dp_high) else $error("pointer high not loaded");
    property p_dp_hold;
        !(bus_wr && paddr[9:3] == 7'h41) |=> $stable(data_pointer);
    endproperty
    a_dp_hold: assert property (p_dp_hold) else $error("pointer changed unasked");
    property p_no_err;
        psel && penable |-> pready && !pslverr;
    endproperty
    a_no_err: assert property (p_no_err) else $error("access not completed cleanly");
    c_cmd: cover property (bus_wr && paddr[9:2] == 8'hE4);
    c_bitop: cover property (bus_wr && paddr[9:2] == 8'hFC);
    c_clr: cover property (flash_busy ##1 !flash_busy);
endmodule : msr_bank_props
`default_nettype wire

/* msr_cpu_model.sv */
// CPU-side model issuing register transfers over APB
`timescale 1ns/1ps
`default_nettype none
module msr_cpu_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    int hang_count = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end
    // Register address is the word index, so the byte address is four times it;
    // callers issue only mapped addresses, each for its own function
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [15:0] din,
                        output logic [31:0] dout);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {22'h00_0000, adr, 2'b00};
        pwdata <= {16'h0000, din};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) hang_count++;
        dout = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows no stale value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : msr_cpu_model
`default_nettype wire

/* msr_bank_bench.sv */
// Self-checking bench for the special register bank
`timescale 1ns/1ps
`default_nettype none
module msr_bank_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, flash_cmd_stb, flash_busy;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] flash_status = 4'h0;
    logic [7:0] flash_command_code;
    logic [15:0] data_pointer;
    logic pin_i, pin_o, pin_oe;
    int miscompares = 0;
    int check_count = 0;
    logic [7:0] rst_a [17] = '{8'h82, 8'h83, 8'h95, 8'hA2, 8'hAC, 8'hAD, 8'hBD, 8'hBE,
        8'hBF, 8'hD8, 8'hDB, 8'hE0, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hF0};
    logic [7:0] msk_a [9] = '{8'hA2, 8'hBD, 8'hAC, 8'hAD, 8'hD8, 8'h95, 8'hBE, 8'hDB, 8'hE7};
    logic [7:0] msk_e [9] = '{8'hF9, 8'h03, 8'h3F, 8'h3F, 8'h7D, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] bit_a [3] = '{8'hE0, 8'hF0, 8'hD8};
    logic [7:0] bit_e [3] = '{8'hFF, 8'hFF, 8'h7D};
    logic [7:0] cs_v [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06};
    logic cs_oe [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    always #12.5 pclk = ~pclk;
    // Pulled-up pin: reads high unless the bank drives it
    assign pin_i = pin_oe ? pin_o : 1'b1;
    msr_bank i_msr_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_status(flash_status), .flash_command_code(flash_command_code),
        .flash_cmd_stb(flash_cmd_stb), .data_pointer(data_pointer),
        .oscillator_input_pin_i(pin_i), .oscillator_input_pin_o(pin_o),
        .oscillator_input_pin_oe(pin_oe), .flash_busy(flash_busy));
    msr_cpu_model i_msr_cpu_model (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        i_msr_cpu_model.xfer(1'b0, a, 16'h0000, d);
        chk(nm, exp, d);
    endtask : rdchk
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [31:0] d;
        i_msr_cpu_model.xfer(1'b1, a, v, d);
    endtask : wr
    task automatic summarize;
        miscompares += i_msr_cpu_model.hang_count;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_a[i]) rdchk(rst_a[i], (rst_a[i] == 8'hE4) ? 32'h70 : 32'h0, "reset");
        $display("test reset values done");
        foreach (msk_a[i]) begin
            wr(msk_a[i], {8'h00, msk_e[i]});
            rdchk(msk_a[i], {24'h00_0000, msk_e[i]}, "masked byte");
        end
        $display("test bit masks done");
        wr(8'h82, 16'h005A);
        wr(8'h83, 16'h00A5);
        @(posedge pclk);
        chk("data pointer", 32'h0000_A55A, {16'h0000, data_pointer});
        rdchk(8'h83, 32'h0000_00A5, "pointer high");
        $display("test data pointer done");
        foreach (bit_a[i]) begin
            wr(bit_a[i], {8'h00, bit_e[i]});
            wr(8'hFC, {bit_a[i], 8'h83});
            rdchk(bit_a[i], {24'h00_0000, bit_e[i] & 8'hF7}, "bit clear");
            wr(8'hFC, {bit_a[i], 8'hC3});
            rdchk(bit_a[i], {24'h00_0000, bit_e[i]}, "bit set");
        end
        $display("test bit access done");
        wr(8'hE4, 16'h005A);
        @(posedge pclk);
        chk("command", 32'h0000_005A, {24'h00_0000, flash_command_code});
        rdchk(8'hE4, 32'h0000_00F0, "flash busy");
        @(posedge pclk);
        flash_status <= 4'h5;
        repeat (2) @(posedge pclk);
        rdchk(8'hE4, 32'h0000_0075, "flash status");
        flash_status <= 4'h0;
        repeat (2) @(posedge pclk);
        rdchk(8'hE4, 32'h0000_0070, "flash idle");
        $display("test flash control done");
        wr(8'hFE, 16'h0003);
        foreach (cs_v[i]) begin
            wr(8'hFD, {8'h00, cs_v[i]});
            @(posedge pclk);
            chk("pin enable", {31'h0, cs_oe[i]}, {31'h0, pin_oe});
            rdchk(8'hFD, {24'h0, {2{cs_oe[i]}}, cs_v[i][5:0]}, "clock select");
        end
        $display("test pin reuse done");
        rdchk(8'hFE, 32'h0000_0000, "port control");
        $display("test port control done");
        summarize();
    end
endmodule : msr_bank_bench
bind msr_bank msr_bank_props i_msr_bank_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_status(flash_status),
    .flash_command_code(flash_command_code), .flash_cmd_stb(flash_cmd_stb),
    .data_pointer(data_pointer), .flash_busy(flash_busy));
`default_nettype wire
